/* hw/gtc_timer.sv */
// Behaviour
// - 16-bit counter, byte writes load live count
// - Instruction clock source counts once per instruction cycle (every four clocks)
// - Off unless on; gate_enable adds gating
// - clock_select picks instr, system, pin, cap-osc
// - System clock gives four counts per instruction
// - External modes count rising source edges
// - sync_disable picks synchronised or raw source
// - Falling edge needed before first counted rise
// - Prescaler divides by 1, 2, 4, 8
// - Prescaler hidden, cleared on count writes
// - Crystal oscillator enable, runs in sleep
// - sync_disable counts without synchroniser
// - Async external counting continues in sleep, wakes
// - Mode switch may skip or add one
// - Single byte reads always return valid value
// - Gate level must equal gate polarity
// - Blocked gate holds count unchanged
// - Rollover FFFF to 0000 sets overflow flag
`include "gtc_consts.svh"

module gtc_timer (
  // Clock and reset
  input  wire logic                   core_clk_i,
  input  wire logic                   rst_i,
  // Register port
  input  wire logic [`GTC_ADDR_W-1:0] reg_addr_i,
  input  wire logic [7:0]             reg_wdata_i,
  input  wire logic                   reg_wr_i,
  input  wire logic                   reg_rd_i,
  output logic      [7:0]             reg_rdata_o,
  // Count sources and gate
  input  wire logic                   external_clock_pin_i,
  input  wire logic                   crystal_in_pin_i,
  input  wire logic                   cap_osc_i,
  input  wire logic                   gate_input_i,
  // Crystal driver
  output logic                        crystal_out_pin_o,
  output logic                        crystal_osc_enable_o,
  // Core power state and events
  input  wire logic                   sleep_i,
  output logic                        overflow_flag_o,
  output logic                        wake_o
);

  gtc_pkg::gtc_tctrl_t tctrl_q, tctrl_d;
  gtc_pkg::gtc_gctrl_t gctrl_q, gctrl_d;
  logic [15:0] cnt_q, cnt_d;
  logic [2:0]  pre_q, pre_d;
  logic [1:0]  phase_q, phase_d;
  logic        ext_s1_q, ext_s2_q, ext_prev_q;
  logic        gate_s1_q, gate_s2_q;
  logic        armed_q, armed_d;
  logic        flag_q, flag_d;
  logic        wake_q, wake_d;
  logic [7:0]  rdata_q, rdata_d;

  logic       ext_raw, ext_lvl, ext_rise, ext_fall;
  logic       gate_lvl, gate_ok, count_en, src_tick, inc, ovf_set;
  logic       cnt_wr, wr_lo, wr_hi;
  logic [2:0] pre_mask;

  assign crystal_osc_enable_o = tctrl_q.crystal_osc_enable;
  // Inverting amplifier; keeps running regardless of sleep_i
  assign crystal_out_pin_o    = tctrl_q.crystal_osc_enable & ~crystal_in_pin_i;
  assign overflow_flag_o      = flag_q;
  assign wake_o               = wake_q;
  assign reg_rdata_o          = rdata_q;

  always_comb begin
    wr_lo  = reg_wr_i && (reg_addr_i == `GTC_ADDR_CNT_LO);
    wr_hi  = reg_wr_i && (reg_addr_i == `GTC_ADDR_CNT_HI);
    cnt_wr = wr_lo || wr_hi;

    // Crystal replaces the pin when the oscillator is enabled
    if (tctrl_q.clock_select == gtc_pkg::GTC_SRC_CAP) begin
      ext_raw = cap_osc_i;
    end else if (tctrl_q.crystal_osc_enable) begin
      ext_raw = crystal_in_pin_i;
    end else begin
      ext_raw = external_clock_pin_i;
    end
    ext_lvl  = tctrl_q.sync_disable ? ext_raw : ext_s2_q;
    gate_lvl = tctrl_q.sync_disable ? gate_input_i : gate_s2_q;
    ext_rise = ext_lvl && !ext_prev_q;
    ext_fall = !ext_lvl && ext_prev_q;

    gate_ok  = (gate_lvl == gctrl_q.gate_polarity);
    count_en = tctrl_q.timer_on && (!gctrl_q.gate_enable || gate_ok);

    case (tctrl_q.clock_select)
      gtc_pkg::GTC_SRC_INSTR: src_tick = (phase_q == `GTC_PHASE_LAST) && !sleep_i;
      gtc_pkg::GTC_SRC_SYS:   src_tick = !sleep_i;
      gtc_pkg::GTC_SRC_EXT,
      gtc_pkg::GTC_SRC_CAP:   src_tick = ext_rise && armed_q && (!sleep_i || tctrl_q.sync_disable);
      default:                src_tick = 1'b0;
    endcase

    case (tctrl_q.prescale_select)
      2'h0:    pre_mask = 3'h0;
      2'h1:    pre_mask = 3'h1;
      2'h2:    pre_mask = 3'h3;
      default: pre_mask = 3'h7;
    endcase
    inc     = src_tick && count_en && ((pre_q & pre_mask) == pre_mask);
    ovf_set = inc && (cnt_q == `GTC_CNT_MAX);

    phase_d = (phase_q == `GTC_PHASE_LAST) ? 2'h0 : phase_q + 2'h1;

    // Cleared whenever counting is off or the count is rewritten
    if (!tctrl_q.timer_on || cnt_wr) begin
      armed_d = 1'b0;
    end else if (ext_fall) begin
      armed_d = 1'b1;
    end else begin
      armed_d = armed_q;
    end

    if (cnt_wr) begin
      pre_d = `GTC_RST_PRE;
    end else if (src_tick && count_en) begin
      pre_d = pre_q + 3'h1;
    end else begin
      pre_d = pre_q;
    end

    // A write beats a coincident increment; software should stop first
    cnt_d = cnt_q;
    if (wr_lo) begin
      cnt_d[7:0] = reg_wdata_i;
    end else if (wr_hi) begin
      cnt_d[15:8] = reg_wdata_i;
    end else if (inc) begin
      cnt_d = cnt_q + 16'h0001;
    end

    tctrl_d = tctrl_q;
    gctrl_d = gctrl_q;
    if (reg_wr_i && (reg_addr_i == `GTC_ADDR_TCTRL)) begin
      tctrl_d = gtc_pkg::gtc_tctrl_t'(reg_wdata_i);
    end
    if (reg_wr_i && (reg_addr_i == `GTC_ADDR_GCTRL)) begin
      gctrl_d = gtc_pkg::gtc_gctrl_t'(reg_wdata_i);
    end

    // Set wins over a write-one clear in the same cycle
    flag_d = ovf_set || (flag_q && !(reg_wr_i && (reg_addr_i == `GTC_ADDR_STATUS)
             && reg_wdata_i[`GTC_STAT_OVF_BIT]));
    wake_d = ovf_set && sleep_i;

    // Whole bytes come from the registered count, never a torn value
    rdata_d = 8'h00;
    if (reg_rd_i) begin
      case (reg_addr_i)
        `GTC_ADDR_CNT_LO: rdata_d = cnt_q[7:0];
        `GTC_ADDR_CNT_HI: rdata_d = cnt_q[15:8];
        `GTC_ADDR_TCTRL:  rdata_d = tctrl_q;
        `GTC_ADDR_GCTRL:  rdata_d = gctrl_q;
        `GTC_ADDR_STATUS: rdata_d = {7'h00, flag_q};
        default:          rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      tctrl_q    <= gtc_pkg::gtc_tctrl_t'(`GTC_RST_TCTRL);
      gctrl_q    <= gtc_pkg::gtc_gctrl_t'(`GTC_RST_GCTRL);
      cnt_q      <= `GTC_RST_CNT;
      pre_q      <= `GTC_RST_PRE;
      phase_q    <= 2'h0;
      ext_s1_q   <= 1'b0;
      ext_s2_q   <= 1'b0;
      ext_prev_q <= 1'b0;
      gate_s1_q  <= 1'b0;
      gate_s2_q  <= 1'b0;
      armed_q    <= 1'b0;
      flag_q     <= 1'b0;
      wake_q     <= 1'b0;
      rdata_q    <= 8'h00;
    end else begin
      tctrl_q    <= tctrl_d;
      gctrl_q    <= gctrl_d;
      cnt_q      <= cnt_d;
      pre_q      <= pre_d;
      phase_q    <= phase_d;
      ext_s1_q   <= ext_raw;
      ext_s2_q   <= ext_s1_q;
      ext_prev_q <= ext_lvl;
      gate_s1_q  <= gate_input_i;
      gate_s2_q  <= gate_s1_q;
      armed_q    <= armed_d;
      flag_q     <= flag_d;
      wake_q     <= wake_d;
      rdata_q    <= rdata_d;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  a_low_byte_load: assert property (wr_lo |=> cnt_q[7:0] == $past(reg_wdata_i))
    else $error("low byte write not loaded");
  a_off_holds: assert property (!tctrl_q.timer_on && !cnt_wr |=> $stable(cnt_q))
    else $error("counter moved while off");
  a_instr_rate: assert property (tctrl_q.clock_select == gtc_pkg::GTC_SRC_INSTR && tctrl_q.timer_on
    && !gctrl_q.gate_enable && tctrl_q.prescale_select == 2'h0 && !sleep_i && !cnt_wr
    |=> cnt_q == $past(cnt_q) + 16'(($past(phase_q) == 2'h3) ? 1 : 0))
    else $error("instruction clock rate wrong");
  a_sys_rate: assert property ((tctrl_q.clock_select == gtc_pkg::GTC_SRC_SYS && tctrl_q.timer_on
    && !gctrl_q.gate_enable && tctrl_q.prescale_select == 2'h0 && !sleep_i && !cnt_wr) [*4]
    |=> cnt_q == $past(cnt_q, 4) + 16'h0004)
    else $error("system clock not four per instruction");
  a_pre_clear: assert property (cnt_wr |=> pre_q == 3'h0)
    else $error("prescaler not cleared on write");
  a_gate_hold: assert property (tctrl_q.timer_on && gctrl_q.gate_enable && gate_lvl != gctrl_q.gate_polarity
    && !cnt_wr |=> $stable(cnt_q))
    else $error("count moved with gate closed");
  a_rollover_flag: assert property (inc && cnt_q == 16'hFFFF && !cnt_wr |=> cnt_q == 16'h0000 && flag_q)
    else $error("rollover did not wrap and flag");
  a_arm_needed: assert property (tctrl_q.clock_select[1] && !armed_q && !cnt_wr |=> $stable(cnt_q))
    else $error("counted before falling edge");
  a_sleep_hold: assert property (sleep_i && !(tctrl_q.clock_select[1] && tctrl_q.sync_disable) && !cnt_wr
    |=> $stable(cnt_q))
    else $error("sync source counted in sleep");
  a_prescale_div: assert property (tctrl_q.prescale_select == 2'h3 && src_tick && count_en && pre_q != 3'h7
    && !cnt_wr |=> $stable(cnt_q))
    else $error("divide by eight passed early");

  // Cycle-exact checks, so a one-off in the count path shows at once
  a_high_byte_load: assert property (wr_hi |=> cnt_q[15:8] == $past(reg_wdata_i))
    else $error("high byte write not loaded");
  a_low_keeps_high: assert property (wr_lo |=> cnt_q[15:8] == $past(cnt_q[15:8]))
    else $error("low byte write disturbed high byte");
  a_high_keeps_low: assert property (wr_hi |=> cnt_q[7:0] == $past(cnt_q[7:0]))
    else $error("high byte write disturbed low byte");
  a_phase_wrap: assert property (phase_q == `GTC_PHASE_LAST |=> phase_q == 2'h0)
    else $error("instruction phase did not wrap");
  a_off_pre_hold: assert property (!tctrl_q.timer_on && !cnt_wr |=> $stable(pre_q))
    else $error("prescaler moved while off");
  a_cap_source: assert property (tctrl_q.clock_select == gtc_pkg::GTC_SRC_CAP |-> ext_raw == cap_osc_i)
    else $error("capacitive oscillator not selected");
  a_sys_step: assert property (tctrl_q.clock_select == gtc_pkg::GTC_SRC_SYS && tctrl_q.timer_on
    && !gctrl_q.gate_enable && tctrl_q.prescale_select == 2'h0 && !sleep_i && !cnt_wr
    |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("system clock missed a count");
  a_async_edge: assert property (tctrl_q.clock_select[1] && tctrl_q.sync_disable && tctrl_q.timer_on
    && !gctrl_q.gate_enable && tctrl_q.prescale_select == 2'h0 && armed_q && ext_raw && !ext_prev_q
    && !cnt_wr |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("raw external edge not counted");
  a_sync_edge: assert property (tctrl_q.clock_select[1] && !tctrl_q.sync_disable && tctrl_q.timer_on
    && !gctrl_q.gate_enable && tctrl_q.prescale_select == 2'h0 && armed_q && !sleep_i
    && ext_s2_q && !ext_prev_q && !cnt_wr |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("synchronised edge not counted");
  a_sync_low_hold: assert property (tctrl_q.clock_select[1] && !tctrl_q.sync_disable && !ext_s2_q && !cnt_wr
    |=> $stable(cnt_q))
    else $error("counted ahead of the synchroniser");
  a_gate_synced: assert property (tctrl_q.timer_on && gctrl_q.gate_enable && !tctrl_q.sync_disable
    && gate_s2_q != gctrl_q.gate_polarity && !cnt_wr |=> $stable(cnt_q))
    else $error("gate bypassed the synchroniser");
  a_arm_on_write: assert property (cnt_wr |=> !armed_q)
    else $error("count write left the edge armed");
  a_arm_on_off: assert property (!tctrl_q.timer_on |=> !armed_q)
    else $error("disabled timer left the edge armed");
  a_div_two: assert property (tctrl_q.prescale_select == 2'h1 && src_tick && count_en && !pre_q[0]
    && !cnt_wr |=> $stable(cnt_q))
    else $error("divide by two passed early");
  a_pre_hold: assert property (!cnt_wr && !(src_tick && count_en) |=> $stable(pre_q))
    else $error("prescaler moved without a tick");
  a_xtal_off: assert property (!tctrl_q.crystal_osc_enable |-> !crystal_out_pin_o)
    else $error("crystal driven while disabled");
  a_gate_open: assert property (tctrl_q.clock_select == gtc_pkg::GTC_SRC_SYS && tctrl_q.timer_on
    && gctrl_q.gate_enable && gate_lvl == gctrl_q.gate_polarity && tctrl_q.prescale_select == 2'h0
    && !sleep_i && !cnt_wr |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("open gate did not count");
  a_flag_set_wins: assert property (ovf_set |=> flag_q)
    else $error("rollover did not set the flag");
  a_flag_rise_cause: assert property (!ovf_set |=> !$rose(flag_q))
    else $error("flag set without rollover");
  a_flag_sticky: assert property (flag_q && !(reg_wr_i && reg_addr_i == `GTC_ADDR_STATUS) |=> flag_q)
    else $error("flag dropped without a clear");
  a_flag_clear: assert property (reg_wr_i && reg_addr_i == `GTC_ADDR_STATUS && reg_wdata_i[`GTC_STAT_OVF_BIT]
    && !ovf_set |=> !flag_q)
    else $error("flag not cleared by software");
  a_wake_pulse: assert property (ovf_set && sleep_i |=> wake_o)
    else $error("no wake on rollover in sleep");
  a_wake_cause: assert property (!(ovf_set && sleep_i) |=> !wake_o)
    else $error("wake without rollover in sleep");
  a_read_low: assert property (reg_rd_i && reg_addr_i == `GTC_ADDR_CNT_LO
    |=> reg_rdata_o == $past(cnt_q[7:0]))
    else $error("low byte read wrong");
  a_read_high: assert property (reg_rd_i && reg_addr_i == `GTC_ADDR_CNT_HI
    |=> reg_rdata_o == $past(cnt_q[15:8]))
    else $error("high byte read wrong");
  a_read_idle: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read data not cleared");

  c_rollover: cover property (ovf_set);
  c_async_sleep: cover property (sleep_i && tctrl_q.sync_disable && inc);
  c_gated_count: cover property (gctrl_q.gate_enable && inc);
  c_wake: cover property (wake_q);
  c_ext_count: cover property (tctrl_q.clock_select == gtc_pkg::GTC_SRC_EXT && inc);

endmodule

/* hw/gtc_consts.svh */
`ifndef GTC_CONSTS_SVH
`define GTC_CONSTS_SVH

// Register offsets (byte-wide registers)
`define GTC_ADDR_W        3
`define GTC_ADDR_CNT_LO   3'h0
`define GTC_ADDR_CNT_HI   3'h1
`define GTC_ADDR_TCTRL    3'h2
`define GTC_ADDR_GCTRL    3'h3
`define GTC_ADDR_STATUS   3'h4

// Reset values
`define GTC_RST_CNT       16'h0000
`define GTC_RST_TCTRL     8'h00
`define GTC_RST_GCTRL     8'h00
`define GTC_RST_PRE       3'h0

// Field positions
`define GTC_STAT_OVF_BIT  0

// Counter limits and timing
`define GTC_CNT_MAX       16'hFFFF
`define GTC_CNT_ZERO      16'h0000
`define GTC_CLK_NS        25
`define GTC_INSTR_NS      100
`define GTC_INSTR_CYC     (`GTC_INSTR_NS / `GTC_CLK_NS)
`define GTC_PHASE_LAST    2'((`GTC_INSTR_CYC) - 1)

`endif

/* hw/gtc_pkg.sv */
package gtc_pkg;

  typedef enum logic [1:0] {
    GTC_SRC_INSTR,
    GTC_SRC_SYS,
    GTC_SRC_EXT,
    GTC_SRC_CAP
  } gtc_src_t;

  // Layout matches the timer_control register, msb first
  typedef struct packed {
    gtc_src_t   clock_select;
    logic [1:0] prescale_select;
    logic       crystal_osc_enable;
    logic       sync_disable;
    logic       spare;
    logic       timer_on;
  } gtc_tctrl_t;

  // Layout matches the gate_control register, msb first
  typedef struct packed {
    logic       gate_enable;
    logic       gate_polarity;
    logic [5:0] spare;
  } gtc_gctrl_t;

endpackage

/* sim/gtc_src_model.sv */
module gtc_src_model (
  // Clock and frame
  input  wire logic core_clk_i,
  input  wire logic run_i,
  // Source waveforms
  output logic      pin_o,
  output logic      xtal_o,
  output logic      cap_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [5:0] ph_q;
  // Low and still between frames, so the first rise is never pre-armed
  always_ff @(posedge core_clk_i) begin
    ph_q   <= run_i ? ph_q + 6'h01 : 6'h00;
    pin_o  <= run_i & ph_q[2];
    xtal_o <= run_i & ph_q[1];
    cap_o  <= run_i & ph_q[3];
  end
endmodule

/* sim/gtc_timer_tb_top.sv */
module gtc_timer_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       gate = 1'b0;
  logic       sleep = 1'b0;
  logic       run = 1'b0;
  logic       wake_seen = 1'b0;
  logic [7:0] rdata;
  logic       pin, xtal, cap, xout, xen, ovf, wake;
  logic [7:0] v;
  int         err_total = 0;
  int         check_count = 0;
  int         cyc = 0;

  gtc_timer uut (
    .core_clk_i(clk), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .external_clock_pin_i(pin), .crystal_in_pin_i(xtal), .cap_osc_i(cap),
    .gate_input_i(gate), .crystal_out_pin_o(xout), .crystal_osc_enable_o(xen),
    .sleep_i(sleep), .overflow_flag_o(ovf), .wake_o(wake)
  );
  gtc_src_model src (.core_clk_i(clk), .run_i(run), .pin_o(pin), .xtal_o(xtal), .cap_o(cap));

  always #12.5 clk = ~clk;

  always @(posedge clk) begin
    if (wake === 1'b1) wake_seen <= 1'b1;
    cyc++;
    // Whole run needs about 5400 cycles
    if (cyc == 12000) begin
      err_total++;
      close_out();
    end
  end

  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Internal sources see n+10 count edges between start and stop
  task automatic measure(input logic [15:0] st, input logic [7:0] tc, input logic [7:0] gc,
                         input logic sl, input int n, input logic [15:0] exp);
    logic [7:0] lo;
    logic [7:0] hi;
    reg_wr(3'h3, gc);
    reg_wr(3'h0, st[7:0]);
    reg_wr(3'h1, st[15:8]);
    reg_wr(3'h2, tc);
    sleep <= sl;
    run <= 1'b1;
    repeat (n) @(posedge clk);
    run <= 1'b0;
    repeat (8) @(posedge clk);
    sleep <= 1'b0;
    reg_wr(3'h2, tc & 8'hFE);
    reg_rd(3'h0, lo);
    reg_rd(3'h1, hi);
    cmp({hi, lo}, exp);
  endtask

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 6; a++) begin
      reg_rd(3'(a), v);
      cmp(16'(v), 16'h0000);
    end
    @(negedge clk);
    cmp({14'h0000, xen, xout}, 16'h0000);
    reg_wr(3'h5, 8'hFF);
    reg_rd(3'h5, v);
    cmp(16'(v), 16'h0000);
    reg_wr(3'h2, 8'h3E);
    reg_rd(3'h2, v);
    cmp(16'(v), 16'h003E);
    @(negedge clk);
    cmp({14'h0000, xen, xout}, 16'h0003);
    measure(16'h00AA, 8'h40, 8'h00, 1'b0, 22, 16'h00AA);
    measure(16'h0000, 8'h01, 8'h00, 1'b0, 70, 16'h0014);
    for (int p = 0; p < 4; p++) begin
      measure(16'h0000, 8'h41 | 8'(p << 4), 8'h00, 1'b0, 64, 16'(74 >> p));
    end
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      gate <= k[0];
      measure(16'h0100, 8'h41, {1'b1, k[1], 6'h00}, 1'b0, 22, (k[0] == k[1]) ? 16'h0120 : 16'h0100);
    end
    measure(16'hFFF0, 8'h41, 8'h00, 1'b0, 12, 16'h0006);
    reg_rd(3'h4, v);
    cmp({v, 6'h00, ovf, wake_seen}, 16'h0102);
    reg_wr(3'h4, 8'h01);
    reg_rd(3'h4, v);
    cmp({v, 7'h00, ovf}, 16'h0000);
    measure(16'h0000, 8'h81, 8'h00, 1'b0, 64, 16'h0007);
    measure(16'h0000, 8'h85, 8'h00, 1'b0, 64, 16'h0007);
    measure(16'h0000, 8'h89, 8'h00, 1'b0, 64, 16'h000F);
    measure(16'h0000, 8'hC1, 8'h00, 1'b0, 64, 16'h0003);
    measure(16'h1234, 8'h81, 8'h00, 1'b1, 64, 16'h1234);
    measure(16'hFFFB, 8'h85, 8'h00, 1'b1, 64, 16'h0002);
    cmp({15'h0000, wake_seen}, 16'h0001);
    // Start-up wait: flag cleared, count preset, exactly 1024 crystal rises to wrap
    reg_wr(3'h4, 8'h01);
    measure(16'hFC00, 8'h8D, 8'h00, 1'b0, 4100, 16'h0000);
    reg_rd(3'h4, v);
    cmp({v, 7'h00, ovf}, 16'h0101);
    close_out();
  end
endmodule
